/* hdl/cfrs_pkg.sv */
// Constants and register map of the field region sequencer
package cfrs_pkg;
    // ==================================================
    // Geometry
    localparam int NUM_REGIONS  = 9;
    localparam int NUM_BOUNDS   = 8;
    localparam int NUM_GATES    = 8;
    localparam int SEQ_W        = 5;
    localparam int LINE_W       = 12;
    localparam int PIX_W        = 13;
    localparam int MASK_W       = 16;
    localparam int ASSIGN_W     = 24;
    localparam int GPAT_W       = 3;
    localparam int REGION_W     = 4;
    // ==================================================
    // Serial frame: 8 address bits then 24 data bits, LSB first
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 24;
    localparam int FRAME_W      = 32;
    localparam int BITCNT_W     = 6;
    // ==================================================
    // Register offsets
    localparam logic [7:0] ADDR_REGION_CFG   = 8'h00;
    localparam logic [7:0] ADDR_BOUNDARY     = 8'h10;
    localparam logic [7:0] ADDR_FIELD_TOTAL  = 8'h20;
    localparam logic [7:0] ADDR_FINAL_PIX    = 8'h21;
    localparam logic [7:0] ADDR_SECOND_START = 8'h22;
    localparam logic [7:0] ADDR_SECOND_GROUP = 8'h23;
    localparam logic [7:0] ADDR_GATE_MASK    = 8'h24;
    localparam logic [7:0] ADDR_GATE_ASSIGN  = 8'h25;
    localparam logic [7:0] ADDR_GATE_LINE1   = 8'h26;
    localparam logic [7:0] ADDR_GATE_LINE2   = 8'h27;
    localparam logic [7:0] ADDR_SEQ_LINE_LEN = 8'h40;
    localparam logic [7:0] ADDR_SEQ_EXTRA    = 8'h60;
    localparam logic [7:0] ADDR_SEQ_ALT      = 8'h80;
    localparam logic [7:0] ADDR_BLOCK_MASK   = 8'hE0;
    // ==================================================
    // Field positions
    localparam int REGION_SWEEP_BIT = 5;
    localparam int REGION_MULTI_BIT = 6;
    localparam int EXTRA_EN_BIT     = 12;
    localparam int ALT_CHOICE_LSB   = 13;
    // ==================================================
    // Values after reset
    localparam logic [11:0] RST_FIELD_TOTAL = 12'h106;
    localparam logic [12:0] RST_LINE_PIX    = 13'h0200;
    localparam logic [12:0] RST_FINAL_PIX   = 13'h0200;
    localparam logic [11:0] RST_BOUNDARY    = 12'hFFF;
    localparam logic [15:0] RST_GATE_MASK   = 16'hFFFF;
    localparam logic [11:0] RST_GATE_LINE   = 12'hFFF;
endpackage : cfrs_pkg

/* hdl/cfrs_field_sequencer.sv */
// Field region sequencer: regions, field timing, sensor gates, second patterns
`timescale 1ns/10ps
// Contract
// (RQ1) Region runs its selected sequence number
// (RQ2) Per-region flag enables sweep operation
// (RQ3) Per-region flag enables multiplier operation
// (RQ4) Reaching boundary line advances to next region
// (RQ5) Eight boundaries make nine consecutive regions
// (RQ6) Field ends after programmed line total
// (RQ7) Last line uses final line pixel length
// (RQ8) Gate line second group starts at pixel
// (RQ9) Gate line second group from selector
// (RQ10) Mask bit pair suppresses gate per line
// (RQ11) Three-bit pattern number per gate output
// (RQ12) Gate pulses on first gate line
// (RQ13) Repeat gate pulses on second gate line
// (RQ14) Gate line: sequence group, then second group
// (RQ15) Per-sequence enable for extra pattern line
// (RQ16) Extra pattern inserted on chosen line
// (RQ17) Extra pattern uses alternate pattern choice
// (RQ18) Extra pattern begins at alternate start pixel
// (RQ19) Software keeps extra pattern off gate line
// (RQ20) Software prefers gate line second settings
// (RQ21) Software never mixes extra pattern, group B
// (RQ22) Slave mode ignores length settings
// (RQ23) Sweep region carries trains across lines
// (RQ24) Multiplier toggle equals setting times length
// (RQ25) Field start resets region and line
module cfrs_field_sequencer import cfrs_pkg::*; #(
    parameter int NUM_SEQ = 32
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Serial programming port
    input  wire logic                  ser_clk,
    input  wire logic                  ser_data,
    input  wire logic                  ser_load_n,
    // Sync pins
    input  wire logic                  sync_slave,
    input  wire logic                  line_sync_in,
    input  wire logic                  field_sync_in,
    // Pattern generator toggle lookup
    input  wire logic [PIX_W-1:0]      toggle_setting,
    input  wire logic [PIX_W-1:0]      pattern_length,
    // Timing status
    output logic                       line_sync_out_r,
    output logic                       field_sync_out_r,
    output logic [REGION_W-1:0]        region_r,
    output logic [LINE_W-1:0]          line_cnt_r,
    output logic [PIX_W-1:0]           pix_cnt_r,
    // Vertical sequence control
    output logic [SEQ_W-1:0]           active_sequence_r,
    output logic                       sweep_active_r,
    output logic                       multiplier_active_r,
    output logic                       vertical_pattern_group_restart_r,
    output logic                       second_active_r,
    output logic [SEQ_W-1:0]           second_group_r,
    output logic [2*PIX_W-1:0]         mult_toggle_pixel_r,
    // Sensor gate outputs
    output logic [NUM_GATES-1:0]       gate_enable_r,
    output logic [ASSIGN_W-1:0]        gate_pattern_r
);
    initial begin
        if (NUM_SEQ < 1 || NUM_SEQ > 32) $error("NUM_SEQ must be 1 to 32");
    end

    // ==================================================
    // Pin synchronisers
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync3_r;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_r <= 6'h07;
            sync2_r <= 6'h07;
            sync3_r <= 6'h07;
        end else begin
            sync1_r <= {field_sync_in, line_sync_in, sync_slave, ser_data, ser_load_n, ser_clk};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    logic sck_rise;
    logic load_rise;
    logic slave_mode;
    logic line_rise;
    logic field_rise;
    assign sck_rise   = sync2_r[0] & ~sync3_r[0];
    assign load_rise  = sync2_r[1] & ~sync3_r[1];
    assign slave_mode = sync2_r[3];
    assign line_rise  = sync2_r[4] & ~sync3_r[4];
    assign field_rise = sync2_r[5] & ~sync3_r[5];

    // ==================================================
    // Serial shifter
    logic [FRAME_W-1:0]  shift_r;
    logic [BITCNT_W-1:0] bitcnt_r;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_r  <= '0;
            bitcnt_r <= '0;
        end else if (sync2_r[1]) begin
            bitcnt_r <= '0;
        end else if (sck_rise) begin
            shift_r <= {sync2_r[2], shift_r[FRAME_W-1:1]};
            if (bitcnt_r != BITCNT_W'(FRAME_W)) bitcnt_r <= bitcnt_r + 1'b1;
        end
    end
    logic               wr_en;
    logic [ADDR_W-1:0]  wr_addr;
    logic [DATA_W-1:0]  wr_data;
    assign wr_en   = load_rise && bitcnt_r == BITCNT_W'(FRAME_W);
    assign wr_addr = shift_r[ADDR_W-1:0];
    assign wr_data = shift_r[FRAME_W-1:ADDR_W];

    // ==================================================
    // Field registers
    logic [SEQ_W-1:0]    region_seq_r   [NUM_REGIONS];
    logic                region_sweep_r [NUM_REGIONS];
    logic                region_multi_r [NUM_REGIONS];
    logic [LINE_W-1:0]   boundary_r     [NUM_BOUNDS];
    logic [LINE_W-1:0]   field_line_total_r;
    logic [PIX_W-1:0]    final_line_pixels_r;
    logic [PIX_W-1:0]    gate_line_second_start_r;
    logic [SEQ_W-1:0]    gate_line_second_group_r;
    logic [MASK_W-1:0]   gate_output_mask_r;
    logic [ASSIGN_W-1:0] gate_pattern_assign_r;
    logic [LINE_W-1:0]   gate_active_line_one_r;
    logic [LINE_W-1:0]   gate_active_line_two_r;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                region_seq_r[i]   <= '0;
                region_sweep_r[i] <= 1'b0;
                region_multi_r[i] <= 1'b0;
            end
            for (int i = 0; i < NUM_BOUNDS; i++) boundary_r[i] <= RST_BOUNDARY;
            field_line_total_r       <= RST_FIELD_TOTAL;
            final_line_pixels_r      <= RST_FINAL_PIX;
            gate_line_second_start_r <= '0;
            gate_line_second_group_r <= '0;
            gate_output_mask_r       <= RST_GATE_MASK;
            gate_pattern_assign_r    <= '0;
            gate_active_line_one_r   <= RST_GATE_LINE;
            gate_active_line_two_r   <= RST_GATE_LINE;
        end else if (wr_en) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                if (wr_addr == ADDR_REGION_CFG + 8'(i)) begin
                    region_seq_r[i]   <= wr_data[SEQ_W-1:0];             // see RQ1
                    region_sweep_r[i] <= wr_data[REGION_SWEEP_BIT];      // see RQ2
                    region_multi_r[i] <= wr_data[REGION_MULTI_BIT];      // see RQ3
                end
            end
            for (int i = 0; i < NUM_BOUNDS; i++) begin
                if (wr_addr == ADDR_BOUNDARY + 8'(i)) boundary_r[i] <= wr_data[LINE_W-1:0];
            end
            case (wr_addr)
                ADDR_FIELD_TOTAL:  field_line_total_r       <= wr_data[LINE_W-1:0];
                ADDR_FINAL_PIX:    final_line_pixels_r      <= wr_data[PIX_W-1:0];
                ADDR_SECOND_START: gate_line_second_start_r <= wr_data[PIX_W-1:0];
                ADDR_SECOND_GROUP: gate_line_second_group_r <= wr_data[SEQ_W-1:0];
                ADDR_GATE_MASK:    gate_output_mask_r       <= wr_data[MASK_W-1:0];
                ADDR_GATE_ASSIGN:  gate_pattern_assign_r    <= wr_data;
                ADDR_GATE_LINE1:   gate_active_line_one_r   <= wr_data[LINE_W-1:0];
                ADDR_GATE_LINE2:   gate_active_line_two_r   <= wr_data[LINE_W-1:0];
                default: ;
            endcase
        end
    end

    // ==================================================
    // Per-sequence registers
    logic [PIX_W-1:0]  line_pixel_total_r         [NUM_SEQ];
    logic              extra_pattern_enable_r     [NUM_SEQ];
    logic [LINE_W-1:0] extra_pattern_line_r       [NUM_SEQ];
    logic [SEQ_W-1:0]  alternate_pattern_choice_r [NUM_SEQ];
    logic [PIX_W-1:0]  alternate_pattern_start_r  [NUM_SEQ];
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int s = 0; s < NUM_SEQ; s++) begin
                line_pixel_total_r[s]         <= RST_LINE_PIX;
                extra_pattern_enable_r[s]     <= 1'b0;
                extra_pattern_line_r[s]       <= '0;
                alternate_pattern_choice_r[s] <= '0;
                alternate_pattern_start_r[s]  <= '0;
            end
        end else if (wr_en) begin
            for (int s = 0; s < NUM_SEQ; s++) begin
                if (wr_addr == ADDR_SEQ_LINE_LEN + 8'(s)) begin
                    line_pixel_total_r[s] <= wr_data[PIX_W-1:0];
                end
                if (wr_addr == ADDR_SEQ_EXTRA + 8'(s)) begin
                    extra_pattern_line_r[s]   <= wr_data[LINE_W-1:0];
                    extra_pattern_enable_r[s] <= wr_data[EXTRA_EN_BIT];   // see RQ15
                end
                if (wr_addr == ADDR_SEQ_ALT + 8'(s)) begin
                    alternate_pattern_start_r[s]  <= wr_data[PIX_W-1:0];
                    alternate_pattern_choice_r[s] <= wr_data[ALT_CHOICE_LSB+:SEQ_W];
                end
            end
        end
    end

    // ==================================================
    // Line and field timing
    logic [SEQ_W-1:0]  cur_seq;
    logic              last_line;
    logic [PIX_W-1:0]  line_len;
    logic              line_end;
    logic              field_end;
    logic [LINE_W-1:0] next_line;
    logic              region_step;
    assign cur_seq   = region_seq_r[region_r];
    assign next_line = line_cnt_r + 1'b1;
    assign last_line = {1'b0, line_cnt_r} + 13'h0001 >= {1'b0, field_line_total_r};
    assign line_len  = last_line ? final_line_pixels_r                    // see RQ7
                                 : line_pixel_total_r[cur_seq];
    assign line_end  = slave_mode ? (line_rise | field_rise)              // see RQ22
                                  : ({1'b0, pix_cnt_r} + 14'h0001 >= {1'b0, line_len});
    assign field_end = slave_mode ? field_rise : (line_end & last_line);  // see RQ6
    assign region_step = region_r < REGION_W'(NUM_BOUNDS)
                         && next_line == boundary_r[region_r[2:0]];       // see RQ4 RQ5

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pix_cnt_r  <= '0;
            line_cnt_r <= '0;
            region_r   <= '0;
        end else if (field_end) begin
            pix_cnt_r  <= '0;
            line_cnt_r <= '0;                                            // see RQ25
            region_r   <= '0;
        end else if (line_end) begin
            pix_cnt_r  <= '0;
            line_cnt_r <= next_line;
            if (region_step) region_r <= region_r + 1'b1;               // see RQ4
        end else begin
            pix_cnt_r <= pix_cnt_r + 1'b1;
        end
    end

    // ==================================================
    // Sequence outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_sync_out_r     <= 1'b0;
            field_sync_out_r    <= 1'b0;
            active_sequence_r   <= '0;
            sweep_active_r      <= 1'b0;
            multiplier_active_r <= 1'b0;
            vertical_pattern_group_restart_r      <= 1'b0;
            mult_toggle_pixel_r <= '0;
        end else begin
            line_sync_out_r     <= line_end;
            field_sync_out_r    <= field_end;
            active_sequence_r   <= cur_seq;                              // see RQ1
            sweep_active_r      <= region_sweep_r[region_r];             // see RQ2
            multiplier_active_r <= region_multi_r[region_r];             // see RQ3
            vertical_pattern_group_restart_r      <= line_end & (field_end | region_step
                                   | ~region_sweep_r[region_r]);         // see RQ23
            if (region_multi_r[region_r]) begin
                mult_toggle_pixel_r <= toggle_setting * pattern_length;  // see RQ24
            end else begin
                mult_toggle_pixel_r <= {{PIX_W{1'b0}}, toggle_setting};
            end
        end
    end

    // ==================================================
    // Second pattern group selection
    logic on_gate_one;
    logic on_gate_two;
    logic on_gate_line;
    logic on_extra_line;
    assign on_gate_one   = line_cnt_r == gate_active_line_one_r;         // see RQ12
    assign on_gate_two   = line_cnt_r == gate_active_line_two_r;         // see RQ13
    assign on_gate_line  = on_gate_one | on_gate_two;
    assign on_extra_line = extra_pattern_enable_r[cur_seq]
                           && line_cnt_r == extra_pattern_line_r[cur_seq]; // see RQ16
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            second_active_r <= 1'b0;
            second_group_r  <= '0;
        end else if (on_gate_line) begin
            second_active_r <= pix_cnt_r >= gate_line_second_start_r;    // see RQ8 RQ14
            second_group_r  <= gate_line_second_group_r;                 // see RQ9
        end else if (on_extra_line) begin
            second_active_r <= pix_cnt_r >= alternate_pattern_start_r[cur_seq]; // see RQ18
            second_group_r  <= alternate_pattern_choice_r[cur_seq];     // see RQ17
        end else begin
            second_active_r <= 1'b0;
            second_group_r  <= second_group_r;
        end
    end

    // ==================================================
    // Sensor gates
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gate_enable_r  <= '0;
            gate_pattern_r <= '0;
        end else begin
            for (int g = 0; g < NUM_GATES; g++) begin
                gate_enable_r[g] <= (on_gate_one & ~gate_output_mask_r[2*g])
                                  | (on_gate_two & ~gate_output_mask_r[2*g+1]); // see RQ10
            end
            gate_pattern_r <= gate_pattern_assign_r;                     // see RQ11
        end
    end

    // ==================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_field_restart;
        field_end |=> region_r == '0 && line_cnt_r == '0 && pix_cnt_r == '0;
    endproperty
    a_field_restart: assert property (p_field_restart) else $error("field start not reset"); // see RQ25

    property p_region_advance;
        line_end && !field_end && region_step |=> region_r == $past(region_r) + 1'b1;
    endproperty
    a_region_advance: assert property (p_region_advance) else $error("region not advanced"); // see RQ4

    property p_region_range;
        region_r <= REGION_W'(NUM_BOUNDS);
    endproperty
    a_region_range: assert property (p_region_range) else $error("region index past nine"); // see RQ5

    property p_field_length;
        !slave_mode && line_end && line_cnt_r + 1'b1 == field_line_total_r
            |=> line_cnt_r == '0 && field_sync_out_r;
    endproperty
    a_field_length: assert property (p_field_length) else $error("field length wrong"); // see RQ6

    property p_gate_off_line;
        !on_gate_line |=> gate_enable_r == '0;
    endproperty
    a_gate_off_line: assert property (p_gate_off_line) else $error("gate outside gate line"); // see RQ12

    property p_gate_mask;
        on_gate_one && !on_gate_two && gate_output_mask_r[0] |=> !gate_enable_r[0];
    endproperty
    a_gate_mask: assert property (p_gate_mask) else $error("masked gate driven"); // see RQ10

    property p_second_switch;
        on_gate_line && pix_cnt_r >= gate_line_second_start_r
            |=> second_active_r && second_group_r == $past(gate_line_second_group_r);
    endproperty
    a_second_switch: assert property (p_second_switch) else $error("second group missed"); // see RQ14

    property p_sweep_hold;
        line_end && !field_end && !region_step && region_sweep_r[region_r] |=> !vertical_pattern_group_restart_r;
    endproperty
    a_sweep_hold: assert property (p_sweep_hold) else $error("sweep truncated at line"); // see RQ23

    property p_multiplier;
        region_multi_r[region_r]
            |=> mult_toggle_pixel_r == $past(toggle_setting) * $past(pattern_length);
    endproperty
    a_multiplier: assert property (p_multiplier) else $error("multiplier toggle wrong"); // see RQ24

    property p_sequence_follow;
        ##1 active_sequence_r == $past(cur_seq);
    endproperty
    a_sequence_follow: assert property (p_sequence_follow) else $error("sequence not selected"); // see RQ1

    c_region_step:  cover property (line_end && region_step);
    c_field_end:    cover property (field_end);
    c_gate_second:  cover property (on_gate_line && second_active_r);
    c_extra_line:   cover property (on_extra_line && !on_gate_line && second_active_r);
endmodule : cfrs_field_sequencer

/* tb/cfrs_ccd_model.sv */
// Sensor side model: records which gate inputs were pulsed
`timescale 1ns/10ps
module cfrs_ccd_model import cfrs_pkg::*; (
    // Clock and control
    input  wire logic                 ref_clk,
    input  wire logic                 clr,
    // Gate inputs from the sequencer
    input  wire logic [NUM_GATES-1:0] gate_in,
    // Observation
    output logic      [NUM_GATES-1:0] gate_seen_r
);
    // Sticky record of every gate that fired
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            gate_seen_r <= '0;
        end else begin
            gate_seen_r <= gate_seen_r | gate_in;
        end
    end
endmodule : cfrs_ccd_model

/* tb/cfrs_field_sequencer_test.sv */
// Self-checking bench of the field region sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module cfrs_field_sequencer_test import cfrs_pkg::*;;
    typedef struct {int ln; int px; logic [3:0] rg; logic [4:0] sq; logic sw; logic mu;
                    logic sa; logic [4:0] gp; logic [7:0] ge; logic [25:0] mt;} cfrs_row_s;
    localparam int PERIOD = 5 * 8 + 5;
    localparam int LIMIT  = 30000;
    logic ref_clk = 1'b0, sys_rst = 1'b1, ser_clk = 1'b0, ser_data = 1'b0, ser_load_n = 1'b1;
    logic clr = 1'b1;
    logic slv = 1'b0, lsi = 1'b0, fsi = 1'b0;
    logic [PIX_W-1:0] toggle_setting = 13'h0009, pattern_length = 13'h0004;
    logic line_sync_out_r, field_sync_out_r, sweep_active_r, multiplier_active_r;
    logic vertical_pattern_group_restart_r, second_active_r;
    logic [REGION_W-1:0] region_r;
    logic [LINE_W-1:0] line_cnt_r;
    logic [PIX_W-1:0] pix_cnt_r;
    logic [SEQ_W-1:0] active_sequence_r, second_group_r;
    logic [2*PIX_W-1:0] mult_toggle_pixel_r;
    logic [NUM_GATES-1:0] gate_enable_r, gate_seen_r;
    logic [ASSIGN_W-1:0] gate_pattern_r;
    int mismatches = 0, n_checks = 0, cyc = 0, n, k;
    // Frames {data, addr}; extra line kept off gate lines, no group B
    logic [31:0] wr[18] = '{32'h000006_20, 32'h000005_21, 32'h000008_43, 32'h000008_47,
        32'h000008_49, 32'h000003_00, 32'h000027_01, 32'h000049_02, 32'h000002_10,
        32'h000004_11, 32'h000003_22, 32'h000011_23, 32'h00FFF6_24, 32'hFAC688_25,
        32'h000001_26, 32'h000005_27, 32'h001004_69, 32'h02A004_89};
    cfrs_row_s rows[7] = '{'{0, 1, 4'h0, 5'h03, 0, 0, 0, 5'h00, 8'h00, 26'h9},
        '{1, 1, 4'h0, 5'h03, 0, 0, 0, 5'h00, 8'h01, 26'h9},
        '{1, 5, 4'h0, 5'h03, 0, 0, 1, 5'h11, 8'h01, 26'h9},
        '{2, 5, 4'h1, 5'h07, 1, 0, 0, 5'h00, 8'h00, 26'h9},
        '{4, 1, 4'h2, 5'h09, 0, 1, 0, 5'h00, 8'h00, 26'h24},
        '{4, 5, 4'h2, 5'h09, 0, 1, 1, 5'h15, 8'h00, 26'h24},
        '{5, 3, 4'h2, 5'h09, 0, 1, 1, 5'h11, 8'h02, 26'h24}};

    cfrs_field_sequencer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_load_n(ser_load_n), .sync_slave(slv),
        .line_sync_in(lsi), .field_sync_in(fsi), .toggle_setting(toggle_setting),
        .pattern_length(pattern_length), .line_sync_out_r(line_sync_out_r),
        .field_sync_out_r(field_sync_out_r), .region_r(region_r), .line_cnt_r(line_cnt_r),
        .pix_cnt_r(pix_cnt_r), .active_sequence_r(active_sequence_r),
        .sweep_active_r(sweep_active_r), .multiplier_active_r(multiplier_active_r),
        .vertical_pattern_group_restart_r(vertical_pattern_group_restart_r), .second_active_r(second_active_r),
        .second_group_r(second_group_r), .mult_toggle_pixel_r(mult_toggle_pixel_r),
        .gate_enable_r(gate_enable_r), .gate_pattern_r(gate_pattern_r));
    cfrs_ccd_model i_ccd (.ref_clk(ref_clk), .clr(clr), .gate_in(gate_enable_r),
        .gate_seen_r(gate_seen_r));

    // ==================================================
    // Clock, timeout and tasks
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic ser_wr(input logic [31:0] f, input int nb);
        ser_load_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            ser_data = f[i];
            repeat (3) @(negedge ref_clk);
            ser_clk = 1'b1;
            repeat (3) @(negedge ref_clk);
            ser_clk = 1'b0;
        end
        repeat (3) @(negedge ref_clk);
        ser_load_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask : ser_wr
    task automatic field_len(output int len);
        len = 0;
        while (field_sync_out_r !== 1'b1 && len < 4000) begin
            @(negedge ref_clk);
            len++;
        end
        `CHK(line_cnt_r, 12'h000)
        `CHK(region_r, 4'h0)
        len = 0;
        do begin
            @(negedge ref_clk);
            len++;
        end while (field_sync_out_r !== 1'b1 && len < 4000);
    endtask : field_len

    // ==================================================
    // Main sequence
    initial begin
        repeat (8) @(negedge ref_clk);
        `CHK({line_cnt_r, region_r, gate_enable_r}, 24'h0)
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 18; i++) ser_wr(wr[i], 32);
        field_len(n);
        field_len(n);
        `CHK(n, PERIOD)
        clr = 1'b0;
        for (int r = 0; r < 7; r++) begin
            k = 0;
            while (!(line_cnt_r === rows[r].ln[11:0] && pix_cnt_r === rows[r].px[12:0])
                   && k < 200) begin
                @(negedge ref_clk);
                k++;
            end
            @(negedge ref_clk);
            `CHK(region_r, rows[r].rg)
            `CHK(active_sequence_r, rows[r].sq)
            `CHK(sweep_active_r, rows[r].sw)
            `CHK(multiplier_active_r, rows[r].mu)
            `CHK(mult_toggle_pixel_r, rows[r].mt)
            `CHK(second_active_r, rows[r].sa)
            if (rows[r].sa) `CHK(second_group_r, rows[r].gp)
            `CHK(gate_enable_r, rows[r].ge)
            `CHK(gate_pattern_r, 24'hFAC688)
        end
        `CHK(gate_seen_r, 8'h03)
        // Short frame and unmapped address must leave the field unchanged
        ser_wr(32'h000003_20, 31);
        ser_wr(32'h000003_30, 32);
        field_len(n);
        field_len(n);
        `CHK(n, PERIOD)
        // Slave mode: external syncs only, lengths ignored
        slv = 1'b1;
        repeat (4) @(negedge ref_clk);
        fsi = 1'b1;
        repeat (20) @(negedge ref_clk);
        `CHK(pix_cnt_r, 13'h0011)
        `CHK(line_cnt_r, 12'h000)
        lsi = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(line_cnt_r, 12'h001)
        `CHK(pix_cnt_r, 13'h0000)
        `CHK(line_sync_out_r, 1'b1)
        `CHK(vertical_pattern_group_restart_r, 1'b1)
        test_done();
    end
endmodule : cfrs_field_sequencer_test
